// *** iap_pkg.sv ***
// Constants, register layout and carrier types for the memory space decoder.
// Assumes a CPU core that presents data-pointer moves as one-cycle requests.
package iap_pkg;
	localparam logic [7:0] MEMORY_CONTROL_ADDR = 8'h96;
	localparam logic [7:0] POINTER_CONFIG_ADDR = 8'ha2;
	localparam logic [7:0] MEMORY_CONTROL_RESET = 8'h00;
	localparam logic [7:0] POINTER_CONFIG_RESET = 8'h00;
	localparam int ACCESS_BIT = 7;
	localparam int SIG_BIT = 3;
	localparam int MAP_BIT = 3;
	localparam int ZERO_BIT = 2;
	localparam logic [15:0] CODE_TOP_8K = 16'h1fff;
	localparam logic [15:0] CODE_TOP_4K = 16'h0fff;
	localparam logic [15:0] FLASH_DATA_SPACE_TOP = 16'h00ff;
	localparam logic [15:0] SIG_TOP = 16'h01ff;

	typedef enum logic [2:0] {
		SPACE_EXTERNAL_DATA_SPACE, SPACE_FLASH_DATA_SPACE, SPACE_CODE, SPACE_EXTERNAL_CODE_SPACE, SPACE_SIG
	} space_e;

	typedef enum logic [0:0] {ST_RUN, ST_WRITE} phase_e;

	typedef struct packed {
		logic valid;
		logic is_code_move;
		logic is_write;
		logic [15:0] addr;
		logic [7:0] wdata;
	} move_req_s;

	typedef struct packed {
		logic valid;
		space_e space;
		logic is_write;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mem_req_s;

	typedef struct packed {
		phase_e phase;
		logic [7:0] memory_control;
		logic [7:0] pointer_config;
		logic [7:0] sfr_rdata;
		mem_req_s mem;
		logic cpu_idle;
		logic resume;
		logic [7:0] move_rdata;
		logic move_rvalid;
	} state_s;
endpackage

// *** iap_memory_space_decode.sv ***
// Memory space decoder for data-pointer moves with in-application programming.
// Assumes flash arrays answer with a one-cycle done pulse and read data.
`timescale 1ns/1ps
module iap_memory_space_decode import iap_pkg::*; #(
	parameter bit SMALL_PART = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic program_fuse_i,
	input wire logic sfr_we_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	input wire move_req_s move_i,
	output logic [7:0] move_rdata_o,
	output logic move_rvalid_o,
	output mem_req_s mem_o,
	input wire logic mem_done_i,
	input wire logic [7:0] mem_rdata_i,
	output logic cpu_idle_o,
	output logic resume_o
);
	state_s s;
	state_s next_s;
	logic access_on;
	logic sig_on;
	logic map_on;
	logic [15:0] code_top;
	space_e space;

	// Internal code top depends on part size
	assign code_top = SMALL_PART ? CODE_TOP_4K : CODE_TOP_8K;
	assign access_on = s.memory_control[ACCESS_BIT] & program_fuse_i;
	assign sig_on = s.pointer_config[SIG_BIT];
	assign map_on = s.memory_control[MAP_BIT];

	always_comb begin
		space = SPACE_EXTERNAL_DATA_SPACE;
		if (move_i.is_code_move) begin
			if (sig_on) begin
				space = SPACE_SIG;
			end else if (move_i.addr <= code_top) begin
				space = SPACE_CODE;
			end else begin
				space = SPACE_EXTERNAL_CODE_SPACE;
			end
		end else if (access_on) begin
			// Map bit is ignored while code space is reachable
			if (move_i.addr <= code_top) begin
				space = sig_on ? SPACE_SIG : SPACE_CODE;
			end else begin
				space = SPACE_EXTERNAL_DATA_SPACE;
			end
			// Addresses between signature top and code top stay in signature
			// space; the array wraps there, a known limitation.
			if (sig_on && move_i.addr > code_top) begin
				space = SPACE_EXTERNAL_DATA_SPACE;
			end
		end else if (map_on && move_i.addr <= FLASH_DATA_SPACE_TOP) begin
			space = SPACE_FLASH_DATA_SPACE;
		end else begin
			space = SPACE_EXTERNAL_DATA_SPACE;
		end
	end

	always_comb begin
		next_s = s;
		next_s.resume = 1'b0;
		next_s.move_rvalid = 1'b0;
		next_s.mem.valid = 1'b0;
		if (sfr_we_i && s.phase == ST_RUN) begin
			if (sfr_addr_i == MEMORY_CONTROL_ADDR) begin
				next_s.memory_control = sfr_wdata_i;
			end
			if (sfr_addr_i == POINTER_CONFIG_ADDR) begin
				next_s.pointer_config = sfr_wdata_i;
			end
		end
		// Fuse off pins the access bit low
		if (!program_fuse_i) begin
			next_s.memory_control[ACCESS_BIT] = 1'b0;
		end
		next_s.pointer_config[ZERO_BIT] = 1'b0;
		next_s.sfr_rdata = 8'h00;
		if (sfr_addr_i == MEMORY_CONTROL_ADDR) begin
			next_s.sfr_rdata = next_s.memory_control;
		end else if (sfr_addr_i == POINTER_CONFIG_ADDR) begin
			next_s.sfr_rdata = next_s.pointer_config;
		end
		case (s.phase)
			ST_RUN: begin
				if (move_i.valid) begin
					next_s.mem.valid = 1'b1;
					next_s.mem.space = space;
					next_s.mem.is_write = move_i.is_write & ~move_i.is_code_move;
					next_s.mem.addr = move_i.addr;
					next_s.mem.wdata = move_i.wdata;
					// Signature writes need signature enable under code access
					if (move_i.is_write && !move_i.is_code_move &&
						(space == SPACE_CODE || space == SPACE_SIG)) begin
						next_s.phase = ST_WRITE;
						next_s.cpu_idle = 1'b1;
					end
				end
				if (mem_done_i && !s.mem.is_write) begin
					next_s.move_rdata = mem_rdata_i;
					next_s.move_rvalid = 1'b1;
				end
			end
			ST_WRITE: begin
				if (mem_done_i) begin
					next_s.phase = ST_RUN;
					next_s.cpu_idle = 1'b0;
					next_s.resume = 1'b1;
				end
			end
			default: next_s.phase = ST_RUN;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.phase <= ST_RUN;
			s.memory_control <= MEMORY_CONTROL_RESET;
			s.pointer_config <= POINTER_CONFIG_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign sfr_rdata_o = s.sfr_rdata;
	assign move_rdata_o = s.move_rdata;
	assign move_rvalid_o = s.move_rvalid;
	assign mem_o = s.mem;
	assign cpu_idle_o = s.cpu_idle;
	assign resume_o = s.resume;

	fuse_forces_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(program_fuse_i) |-> !s.memory_control[ACCESS_BIT])
		else $error("Access bit set with fuse off");
	idle_in_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		s.phase == ST_WRITE |-> cpu_idle_o)
		else $error("CPU not idle during write");
	resume_after_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
		s.phase == ST_WRITE && mem_done_i |=> resume_o && !cpu_idle_o)
		else $error("No resume after write done");
	code_access_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
		move_i.valid && s.phase == ST_RUN && !move_i.is_code_move && access_on
		&& !sig_on && move_i.addr <= code_top |=> mem_o.space == SPACE_CODE)
		else $error("Code access move not routed to code");
	flash_data_space_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
		move_i.valid && s.phase == ST_RUN && !move_i.is_code_move &&
		!access_on && map_on && move_i.addr <= 16'h00ff
		|=> mem_o.valid && mem_o.space == SPACE_FLASH_DATA_SPACE)
		else $error("Flash data map miss");
	code_split_a: assert property (@(posedge clk_i) disable iff (rst_i)
		move_i.valid && s.phase == ST_RUN && move_i.is_code_move && !sig_on
		&& move_i.addr > code_top |=> mem_o.space == SPACE_EXTERNAL_CODE_SPACE)
		else $error("Code move above top not external");
	sig_code_move_a: assert property (@(posedge clk_i) disable iff (rst_i)
		move_i.valid && s.phase == ST_RUN && move_i.is_code_move && sig_on
		|=> mem_o.space == SPACE_SIG)
		else $error("Code move missed signature");
	sig_upper_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
		move_i.valid && s.phase == ST_RUN && !move_i.is_code_move && access_on
		&& sig_on && move_i.addr > code_top |=> mem_o.space == SPACE_EXTERNAL_DATA_SPACE)
		else $error("Upper data not external");
	write_starts_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
		move_i.valid && s.phase == ST_RUN && move_i.is_write &&
		!move_i.is_code_move && access_on && move_i.addr <= code_top
		|=> cpu_idle_o)
		else $error("Program write did not idle CPU");
endmodule

// *** flash_bus_model.sv ***
// Behavioural flash arrays and external bus behind the space decoder.
// Assumes one-cycle request pulses; answers on the next cycle or seven cycles after the request.
`timescale 1ns/1ps
module flash_bus_model import iap_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire mem_req_s mem_i,
	output logic done_o,
	output logic [7:0] rdata_o
);
	logic busy;
	logic [15:0] a;
	int cnt;
	initial begin
		done_o = 1'b0;
		rdata_o = 8'h00;
		busy = 1'b0;
	end
	// Idle bus toggles so a stale byte can never pass as read data
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if (rst_i) begin
			busy <= 1'b0;
		end else if (mem_i.valid) begin
			busy <= 1'b1;
			a <= mem_i.addr;
			cnt <= mem_i.addr[2] ? 6 : 0;
		end else if (busy && cnt > 0) begin
			cnt <= cnt - 1;
		end else if (busy) begin
			busy <= 1'b0;
			done_o <= 1'b1;
			rdata_o <= a[7:0] ^ 8'h5a;
		end
	end
endmodule

// *** iap_memory_space_decode_bench.sv ***
// Self-checking bench for the memory space decoder, 8K variant.
// Assumes the flash bus model answers every request it is given.
`timescale 1ns/1ps
module iap_memory_space_decode_bench import iap_pkg::*; ;
	logic clk_i = 0, rst_i = 1, program_fuse_i = 1, sfr_we_i = 0;
	logic mem_done_i, cpu_idle_o, resume_o, move_rvalid_o;
	logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00;
	logic [7:0] sfr_rdata_o, move_rdata_o, mem_rdata_i;
	move_req_s move_i = '0;
	mem_req_s mem_o;
	int bad_count = 0, checked = 0;
	logic [31:0] seed = 32'hf5b2;
	bit acc, sig, dm;
	logic [18:0] sq[$];
	logic [7:0] dq[$];
	logic [8:0] wq[$];
	logic [15:0] bnd[6] = '{16'h00ff, 16'h0100, 16'h01ff, 16'h1fff,
		16'h2000, 16'h0000};
	always #12.5 clk_i = ~clk_i;
	iap_memory_space_decode dut(.clk_i(clk_i), .rst_i(rst_i),
		.program_fuse_i(program_fuse_i), .sfr_we_i(sfr_we_i),
		.sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
		.sfr_rdata_o(sfr_rdata_o), .move_i(move_i),
		.move_rdata_o(move_rdata_o), .move_rvalid_o(move_rvalid_o),
		.mem_o(mem_o), .mem_done_i(mem_done_i), .mem_rdata_i(mem_rdata_i),
		.cpu_idle_o(cpu_idle_o), .resume_o(resume_o));
	flash_bus_model fm(.clk_i(clk_i), .rst_i(rst_i), .mem_i(mem_o),
		.done_o(mem_done_i), .rdata_o(mem_rdata_i));
	task chk(input logic [18:0] got, exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task end_sim;
		$display("checks %0d errors %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function space_e sp(bit c, logic [15:0] a);
		if (c) return sig ? SPACE_SIG : a <= CODE_TOP_8K ? SPACE_CODE
			: SPACE_EXTERNAL_CODE_SPACE;
		if (acc) return a > CODE_TOP_8K ? SPACE_EXTERNAL_DATA_SPACE : sig ? SPACE_SIG
			: SPACE_CODE;
		return dm && a <= FLASH_DATA_SPACE_TOP ? SPACE_FLASH_DATA_SPACE : SPACE_EXTERNAL_DATA_SPACE;
	endfunction
	task sw(input logic [7:0] a, d);
		@(posedge clk_i);
		sfr_we_i <= 1'b1;
		sfr_addr_i <= a;
		sfr_wdata_i <= d;
		@(posedge clk_i);
		sfr_we_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, e);
		@(posedge clk_i);
		sfr_addr_i <= a;
		repeat (2) @(posedge clk_i);
		#1 chk({11'h0, sfr_rdata_o}, {11'h0, e});
	endtask
	// A stray request during a write must be ignored, not queued
	task mv(input bit c, w, input logic [15:0] a);
		int n;
		@(posedge clk_i);
		move_i <= '{1'b1, c, w, a, 8'h3c};
		sq.push_back({sp(c, a), a});
		wq.push_back({w & ~c, 8'h3c});
		if (!w) dq.push_back(a[7:0] ^ 8'h5a);
		n = 0;
		do begin
			@(posedge clk_i);
			move_i.valid <= w && n == 1;
			#1;
			if (w && n == 0) chk(19'(cpu_idle_o), 19'h1);
			n++;
		end while (!(move_rvalid_o | resume_o) && n < 60);
		if (n >= 60) bad_count++;
		if (w) chk(19'(cpu_idle_o), 19'h0);
		if (w) chk(19'(resume_o), 19'h1);
	endtask
	always @(posedge clk_i) if (!rst_i) begin
		if (mem_o.valid) chk({mem_o.space, mem_o.addr},
			sq.size() ? sq.pop_front() : 19'h7ffff);
		if (mem_o.valid) chk(19'({mem_o.is_write, mem_o.wdata}),
			19'(wq.size() ? wq.pop_front() : 9'h1ff));
		if (move_rvalid_o) chk({11'h0, move_rdata_o},
			{11'h0, dq.size() ? dq.pop_front() : 8'hxx});
	end
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h96, 8'h00);
		rd(8'ha2, 8'h00);
		program_fuse_i <= 1'b0;
		sw(8'h96, 8'h88);
		rd(8'h96, 8'h08);
		sw(8'ha2, 8'hff);
		rd(8'ha2, 8'hfb);
		rd(8'h55, 8'h00);
		{acc, sig, dm} = 3'b011;
		mv(1'b0, 1'b0, 16'h0010);
		program_fuse_i <= 1'b1;
		for (int m = 0; m < 8; m++) begin
			{acc, sig, dm} = m[2:0];
			sw(8'h96, {acc, 3'b0, dm, 3'b0});
			sw(8'ha2, {4'h0, sig, 3'b0});
			foreach (bnd[j]) for (int c = 0; c < 2; c++)
				mv(c[0], 1'b0, j < 5 ? bnd[j] : 16'(rnd()));
		end
		{acc, sig} = 2'b10;
		sw(8'h96, 8'h80);
		sw(8'ha2, 8'h00);
		mv(1'b0, 1'b1, 16'h0124);
		rd(8'h96, 8'h80);
		sig = 1;
		sw(8'ha2, 8'h08);
		mv(1'b0, 1'b1, 16'h01ff);
		end_sim;
	end
	// Roughly ten times the expected run length
	initial begin
		#200000;
		bad_count++;
		end_sim;
	end
endmodule
